// ==== rtl/sleep_clock_gating_manager.v ====
// clock and power manager: per-unit sleep enable and force registers,
// a status register, and a sleep handshake cell per unit.
// assumes a four-phase control-bus master on the same clock, and unit
// sleep requests that come from logic on the same clock.
//
// How it works
// - class 1 sleep follows its enable bit directly.
// - class 1 units get no handshake; enable sleeps them unconditionally.
// - class 2 sleeps while enable is set and the unit requests, or while forced.
// - class 2 wakes once enable clears or the request drops.
// - class 3 enable raises sleep-initiate to ask the unit's permission.
// - class 3 unit answers with a request; then sleep is asserted.
// - clearing class 3 enable drops sleep-initiate and sleep at once.
// - either the unit or the manager may end class 3 sleep.
// - a force bit asserts sleep regardless of any request.
// - on class 1 units force acts exactly like enable.
// - status reads each unit's sleep state, one meaning asleep.
// - each unit owns one same-position bit in all three registers.
// - bit 0 two-wire unit, bit 1 reserved, bits 2-8 class 2 units.
// - bits 9-13 are pins, two serial ports, interrupt unit, timer clock.
// - reset: enable and force upper bits zero, status upper bits one.
// - status at 0x0b8 read-only, enable 0x0b9 and force 0x0ba writable.
`timescale 1ns/1ps
`include "sleep_clock_gating_manager_regs.vh"

module sleep_clock_gating_manager (
    input  wire        clock,                         // system clock, 250 MHz
    input  wire        srst,                          // synchronous reset, high
    // control register bus
    input  wire [9:0]  ctrlAddr,                      // register address
    input  wire        ctrlRead,                      // read request, held to ack
    input  wire        ctrlWrite,                     // write request, held to ack
    input  wire [31:0] ctrlWrData,                    // write data
    output wire [31:0] ctrlRdData,                    // read data, valid with ack
    output wire        ctrlAck,                       // ack, held until request drops
    // class 3 unit
    input  wire        twoWireBusUnitSleepRequest,    // permission granted
    output wire        twoWireBusUnitSleepInitiate,   // permission asked
    output wire        twoWireBusUnitSleep_n,         // sleep, low
    // class 2 units
    input  wire        processorCoreSleepRequest,     // may sleep
    input  wire        transferEngineSleepRequest,    // may sleep
    input  wire        bridgeSleepRequest,            // may sleep
    input  wire        decompressorSleepRequest,      // may sleep
    input  wire        externalBusUnitSleepRequest,   // may sleep
    input  wire        memoryControllerSleepRequest,  // may sleep
    input  wire        busArbiterSleepRequest,        // may sleep
    output wire        processorCoreSleep_n,          // sleep, low
    output wire        transferEngineSleep_n,         // sleep, low
    output wire        bridgeSleep_n,                 // sleep, low
    output wire        decompressorSleep_n,           // sleep, low
    output wire        externalBusUnitSleep_n,        // sleep, low
    output wire        memoryControllerSleep_n,       // sleep, low
    output wire        busArbiterSleep_n,             // sleep, low
    // class 1 units
    output wire        generalPinUnitSleep_n,         // sleep, low
    output wire        serialPortZeroSleep_n,         // sleep, low
    output wire        serialPortOneSleep_n,          // sleep, low
    output wire        interruptControllerSleep_n,    // sleep, low
    output wire        coreTimerClockSleep_n          // sleep, low
);

    // ======================================================================
    // declarations
    reg  [`UNIT_COUNT-1:0] sleepEnable_r;
    reg  [`UNIT_COUNT-1:0] sleepEnable_nxt;
    reg  [`UNIT_COUNT-1:0] sleepForce_r;
    reg  [`UNIT_COUNT-1:0] sleepForce_nxt;
    reg                    ack_r;
    reg                    ack_nxt;
    reg  [31:0]            rdData_r;
    reg  [31:0]            rdData_nxt;

    wire [`UNIT_COUNT-1:0] unitRequest;
    wire [`UNIT_COUNT-1:0] unitSleep_n;
    wire [`UNIT_COUNT-1:0] unitInitiate;
    wire [`UNIT_COUNT-1:0] unitAsleep;
    wire [31:0]            statusWord;
    wire [31:0]            enableWord;
    wire [31:0]            forceWord;
    wire                   hitStatus;
    wire                   hitEnable;
    wire                   hitForce;
    wire                   hitAny;
    wire                   request;
    wire                   accept;

    // ======================================================================
    // unit request gathering, one bit per unit
    assign unitRequest[`BIT_TWO_WIRE_BUS]    = twoWireBusUnitSleepRequest;
    assign unitRequest[`BIT_RESERVED_ONE]    = 1'b0;
    assign unitRequest[`BIT_PROCESSOR_CORE]  = processorCoreSleepRequest;
    assign unitRequest[`BIT_TRANSFER_ENGINE] = transferEngineSleepRequest;
    assign unitRequest[`BIT_BRIDGE]          = bridgeSleepRequest;
    assign unitRequest[`BIT_DECOMPRESSOR]    = decompressorSleepRequest;
    assign unitRequest[`BIT_EXTERNAL_BUS]    = externalBusUnitSleepRequest;
    assign unitRequest[`BIT_MEMORY_CTRL]     = memoryControllerSleepRequest;
    assign unitRequest[`BIT_BUS_ARBITER]     = busArbiterSleepRequest;
    // class 1 units never ask
    assign unitRequest[`BIT_GENERAL_PIN]     = 1'b0;
    assign unitRequest[`BIT_SERIAL_ZERO]     = 1'b0;
    assign unitRequest[`BIT_SERIAL_ONE]      = 1'b0;
    assign unitRequest[`BIT_INTERRUPT_CTRL]  = 1'b0;
    assign unitRequest[`BIT_CORE_TIMER]      = 1'b0;

    // ======================================================================
    // one handshake cell per unit, class chosen by bit position
    genvar i;
    generate
        for (i = 0; i < `UNIT_COUNT; i = i + 1) begin : gUnit
            if (i == `BIT_TWO_WIRE_BUS) begin : gClass3
                unit_sleep_cell #(
                    .UNIT_CLASS (`CLASS_THREE)
                ) uCell (
                    .clock         (clock),
                    .srst          (srst),
                    .enable        (sleepEnable_r[i]),
                    .forceBit      (sleepForce_r[i]),
                    .sleepRequest  (unitRequest[i]),
                    .sleep_n       (unitSleep_n[i]),
                    .sleepInitiate (unitInitiate[i])
                );
            end else if (i >= `FIRST_CLASS2_BIT && i <= `LAST_CLASS2_BIT) begin : gClass2
                unit_sleep_cell #(
                    .UNIT_CLASS (`CLASS_TWO)
                ) uCell (
                    .clock         (clock),
                    .srst          (srst),
                    .enable        (sleepEnable_r[i]),
                    .forceBit      (sleepForce_r[i]),
                    .sleepRequest  (unitRequest[i]),
                    .sleep_n       (unitSleep_n[i]),
                    .sleepInitiate (unitInitiate[i])
                );
            end else if (i >= `FIRST_CLASS1_BIT && i <= `LAST_CLASS1_BIT) begin : gClass1
                unit_sleep_cell #(
                    .UNIT_CLASS (`CLASS_ONE)
                ) uCell (
                    .clock         (clock),
                    .srst          (srst),
                    .enable        (sleepEnable_r[i]),
                    .forceBit      (sleepForce_r[i]),
                    .sleepRequest  (unitRequest[i]),
                    .sleep_n       (unitSleep_n[i]),
                    .sleepInitiate (unitInitiate[i])
                );
            end else begin : gReserved
                // reserved position: no unit, reads as awake
                assign unitSleep_n[i]  = 1'b1;
                assign unitInitiate[i] = 1'b0;
            end
            assign unitAsleep[i] = ~unitSleep_n[i];
        end
    endgenerate

    // ======================================================================
    // unit outputs, each straight from its cell's flop
    assign twoWireBusUnitSleep_n       = unitSleep_n[`BIT_TWO_WIRE_BUS];
    assign twoWireBusUnitSleepInitiate = unitInitiate[`BIT_TWO_WIRE_BUS];
    assign processorCoreSleep_n        = unitSleep_n[`BIT_PROCESSOR_CORE];
    assign transferEngineSleep_n       = unitSleep_n[`BIT_TRANSFER_ENGINE];
    assign bridgeSleep_n               = unitSleep_n[`BIT_BRIDGE];
    assign decompressorSleep_n         = unitSleep_n[`BIT_DECOMPRESSOR];
    assign externalBusUnitSleep_n      = unitSleep_n[`BIT_EXTERNAL_BUS];
    assign memoryControllerSleep_n     = unitSleep_n[`BIT_MEMORY_CTRL];
    assign busArbiterSleep_n           = unitSleep_n[`BIT_BUS_ARBITER];
    assign generalPinUnitSleep_n       = unitSleep_n[`BIT_GENERAL_PIN];
    assign serialPortZeroSleep_n       = unitSleep_n[`BIT_SERIAL_ZERO];
    assign serialPortOneSleep_n        = unitSleep_n[`BIT_SERIAL_ONE];
    assign interruptControllerSleep_n  = unitSleep_n[`BIT_INTERRUPT_CTRL];
    assign coreTimerClockSleep_n       = unitSleep_n[`BIT_CORE_TIMER];

    // ======================================================================
    // register words as read back
    // status shows the registered sleep outputs, so it lags enable by one edge
    assign statusWord = {`STATUS_UPPER_VALUE, `GAP_BITS_VALUE,
                         unitAsleep & `UNIT_FIELD_MASK};
    assign enableWord = {`CTRL_UPPER_VALUE, `GAP_BITS_VALUE, sleepEnable_r};
    assign forceWord  = {`CTRL_UPPER_VALUE, `GAP_BITS_VALUE, sleepForce_r};

    // ======================================================================
    // address decode
    assign hitStatus = (ctrlAddr == `ADDR_SLEEP_STATUS);
    assign hitEnable = (ctrlAddr == `ADDR_SLEEP_ENABLE);
    assign hitForce  = (ctrlAddr == `ADDR_SLEEP_FORCE);
    assign hitAny    = hitStatus | hitEnable | hitForce;
    assign request   = ctrlRead | ctrlWrite;
    // one access per request: taken on the edge that raises ack
    assign accept    = request & hitAny & ~ack_r;

    // ======================================================================
    // register next values
    always @* begin
        sleepEnable_nxt = sleepEnable_r;
        sleepForce_nxt  = sleepForce_r;
        if (accept && ctrlWrite) begin
            // reserved bits are not stored, so they always read zero
            if (hitEnable) begin
                sleepEnable_nxt = ctrlWrData[`UNIT_COUNT-1:0] & `UNIT_FIELD_MASK;
            end
            if (hitForce) begin
                sleepForce_nxt = ctrlWrData[`UNIT_COUNT-1:0] & `UNIT_FIELD_MASK;
            end
            // status is read-only: a write is acked and dropped
        end
    end

    // ======================================================================
    // read data and four-phase ack
    always @* begin
        ack_nxt    = ack_r;
        rdData_nxt = rdData_r;
        if (!request) begin
            ack_nxt    = 1'b0;
            rdData_nxt = `DATA_ZERO;
        end else if (accept) begin
            ack_nxt    = 1'b1;
            rdData_nxt = `DATA_ZERO;
            if (ctrlRead) begin
                case (1'b1)
                    hitStatus: begin
                        rdData_nxt = statusWord;
                    end
                    hitEnable: begin
                        rdData_nxt = enableWord;
                    end
                    hitForce: begin
                        rdData_nxt = forceWord;
                    end
                    default: begin
                        rdData_nxt = `DATA_ZERO;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // register flops
    always @(posedge clock) begin
        if (srst) begin
            sleepEnable_r <= `UNIT_FIELD_RESET;
            sleepForce_r  <= `UNIT_FIELD_RESET;
            ack_r         <= 1'b0;
            rdData_r      <= `DATA_ZERO;
        end else begin
            sleepEnable_r <= sleepEnable_nxt;
            sleepForce_r  <= sleepForce_nxt;
            ack_r         <= ack_nxt;
            rdData_r      <= rdData_nxt;
        end
    end

    // unmapped addresses are never acked; the bus master times out
    assign ctrlAck    = ack_r;
    assign ctrlRdData = rdData_r;

endmodule // sleep_clock_gating_manager

// ==== inc/sleep_clock_gating_manager_regs.vh ====
// constants for the sleep clock gating manager: control-bus addresses,
// unit bit positions, unit classes and reset values.
// assumes a 10-bit control-bus address and 32-bit data words.
`ifndef SLEEP_CLOCK_GATING_MANAGER_REGS_VH
`define SLEEP_CLOCK_GATING_MANAGER_REGS_VH

// ==========================================================================
// control-bus addresses
`define CTRL_ADDR_W            10
`define ADDR_SLEEP_STATUS      10'h0b8
`define ADDR_SLEEP_ENABLE      10'h0b9
`define ADDR_SLEEP_FORCE       10'h0ba

// ==========================================================================
// unit bit positions, shared by enable, force and status
`define UNIT_COUNT             14
`define BIT_TWO_WIRE_BUS       0
`define BIT_RESERVED_ONE       1
`define BIT_PROCESSOR_CORE     2
`define BIT_TRANSFER_ENGINE    3
`define BIT_BRIDGE             4
`define BIT_DECOMPRESSOR       5
`define BIT_EXTERNAL_BUS       6
`define BIT_MEMORY_CTRL        7
`define BIT_BUS_ARBITER        8
`define BIT_GENERAL_PIN        9
`define BIT_SERIAL_ZERO        10
`define BIT_SERIAL_ONE         11
`define BIT_INTERRUPT_CTRL     12
`define BIT_CORE_TIMER         13
`define FIRST_CLASS2_BIT       2
`define LAST_CLASS2_BIT        8
`define FIRST_CLASS1_BIT       9
`define LAST_CLASS1_BIT        13

// ==========================================================================
// unit classes
`define CLASS_NONE             2'h0
`define CLASS_ONE              2'h1
`define CLASS_TWO              2'h2
`define CLASS_THREE            2'h3

// ==========================================================================
// field layout and reset values
`define UNIT_FIELD_MASK        14'h3ffd
`define UNIT_FIELD_RESET       14'h0000
`define GAP_BITS_W             2
`define GAP_BITS_VALUE         2'h0
`define UPPER_W                16
`define CTRL_UPPER_VALUE       16'h0000
`define STATUS_UPPER_VALUE     16'hffff
`define DATA_ZERO              32'h00000000

`endif

// ==== rtl/unit_sleep_cell.v ====
// one unit's sleep handshake, class chosen by parameter.
// assumes enable, force and sleep request all come from the system clock.
`timescale 1ns/1ps
`include "sleep_clock_gating_manager_regs.vh"

module unit_sleep_cell #(
    parameter [1:0] UNIT_CLASS = `CLASS_ONE
) (
    input  wire clock,          // system clock
    input  wire srst,           // synchronous reset, high
    input  wire enable,         // enable bit for this unit
    input  wire forceBit,       // force bit for this unit
    input  wire sleepRequest,   // request from the unit (class 2 and 3)
    output wire sleep_n,        // active-low sleep to the unit
    output wire sleepInitiate   // permission request (class 3 only)
);

    reg  sleep_n_r;
    reg  sleepInit_r;
    reg  sleepNext;
    reg  initNext;

    // ======================================================================
    // next state per class
    always @* begin
        sleepNext = 1'b0;
        initNext  = 1'b0;
        case (UNIT_CLASS)
            `CLASS_ONE: begin
                sleepNext = enable | forceBit;
            end
            `CLASS_TWO: begin
                // request withdrawn or enable cleared ends sleep
                sleepNext = (enable & sleepRequest) | forceBit;
            end
            `CLASS_THREE: begin
                initNext  = enable;
                // sleep once asked and granted, or at once when forced; either side may end it
                sleepNext = (enable & sleepInit_r & sleepRequest)
                          | forceBit;
            end
            default: begin
                sleepNext = 1'b0;
                initNext  = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // registered outputs, awake after reset
    always @(posedge clock) begin
        if (srst) begin
            sleep_n_r   <= 1'b1;
            sleepInit_r <= 1'b0;
        end else begin
            sleep_n_r   <= ~sleepNext;
            sleepInit_r <= initNext;
        end
    end

    assign sleep_n       = sleep_n_r;
    assign sleepInitiate = sleepInit_r;

endmodule // unit_sleep_cell

// ==== dv/sleep_gating_props.sv ====
// checker: bus handshake and unit sleep outputs of the sleep clock gating manager.
// assumes a master that holds each request until it has seen the acknowledge.
`timescale 1ns/1ps
`include "sleep_clock_gating_manager_regs.vh"

module sleep_gating_props (
    input logic        clock,                       // system clock
    input logic        srst,                        // synchronous reset
    input logic [9:0]  ctrlAddr,                    // register address
    input logic        ctrlRead,                    // read request
    input logic        ctrlWrite,                   // write request
    input logic [31:0] ctrlRdData,                  // read data
    input logic        ctrlAck,                     // acknowledge
    input logic        twoWireBusUnitSleepRequest,  // class 3 grant
    input logic        twoWireBusUnitSleepInitiate, // class 3 ask
    input logic        twoWireBusUnitSleep_n,       // class 3 sleep
    input logic        processorCoreSleepRequest,   // class 2 request
    input logic        processorCoreSleep_n,        // class 2 sleep
    input logic        coreTimerClockSleep_n        // class 1 sleep
);
    wire req    = ctrlRead | ctrlWrite;
    wire toSt   = ctrlAddr == `ADDR_SLEEP_STATUS;
    wire toEn   = ctrlAddr == `ADDR_SLEEP_ENABLE;
    wire toFo   = ctrlAddr == `ADDR_SLEEP_FORCE;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // ==========
    // register bus
    ack_timing_a: assert property (req && (toSt || toEn || toFo) && !ctrlAck |=> ctrlAck)
        else $error("mapped request not acknowledged next cycle");
    unmapped_ignored_a: assert property (req && !(toSt || toEn || toFo) && !ctrlAck |=> !ctrlAck)
        else $error("unmapped address acknowledged");
    ack_release_a: assert property (ctrlAck && !req |=> !ctrlAck && ctrlRdData == `DATA_ZERO)
        else $error("acknowledge outlived its request");
    idle_data_a: assert property (!ctrlAck && !req |-> ctrlRdData == `DATA_ZERO)
        else $error("read data driven while idle");
    status_upper_a: assert property (ctrlAck && ctrlRead && toSt |-> ctrlRdData[31:14] == 18'h3fffc && !ctrlRdData[1])
        else $error("status upper or reserved bits wrong");
    ctrl_reserved_a: assert property (ctrlAck && ctrlRead && !toSt |-> ctrlRdData[31:14] == 18'h0 && !ctrlRdData[1])
        else $error("reserved control bits read nonzero");

    // ==========
    // unit handshakes; the manager's own bits are hidden, so causes are traced to bus writes
    reset_awake_a: assert property (disable iff (1'b0) srst |=> coreTimerClockSleep_n && processorCoreSleep_n && twoWireBusUnitSleep_n && !twoWireBusUnitSleepInitiate)
        else $error("unit not awake after reset");
    grant_sleeps_a: assert property (twoWireBusUnitSleepInitiate && twoWireBusUnitSleepRequest ##1 twoWireBusUnitSleepInitiate |-> !twoWireBusUnitSleep_n)
        else $error("granted class 3 unit not put to sleep");
    initiate_cause_a: assert property ($changed(twoWireBusUnitSleepInitiate) |-> $past(srst || ctrlAck && toEn))
        else $error("initiate moved without enable write");
    class1_cause_a: assert property ($changed(coreTimerClockSleep_n) |-> $past(srst || ctrlAck && (toEn || toFo)))
        else $error("class 1 sleep moved without register write");
    class2_sleep_a: assert property ($fell(processorCoreSleep_n) |-> $past(processorCoreSleepRequest || ctrlAck && toFo))
        else $error("class 2 slept without request or force");
    class2_wake_a: assert property ($rose(processorCoreSleep_n) |-> $past(!processorCoreSleepRequest || srst || ctrlAck && (toEn || toFo)))
        else $error("class 2 woke without cause");
endmodule // sleep_gating_props

bind sleep_clock_gating_manager sleep_gating_props props (
    .clock(clock), .srst(srst), .ctrlAddr(ctrlAddr), .ctrlRead(ctrlRead),
    .ctrlWrite(ctrlWrite), .ctrlRdData(ctrlRdData), .ctrlAck(ctrlAck),
    .twoWireBusUnitSleepRequest(twoWireBusUnitSleepRequest),
    .twoWireBusUnitSleepInitiate(twoWireBusUnitSleepInitiate),
    .twoWireBusUnitSleep_n(twoWireBusUnitSleep_n),
    .processorCoreSleepRequest(processorCoreSleepRequest),
    .processorCoreSleep_n(processorCoreSleep_n), .coreTimerClockSleep_n(coreTimerClockSleep_n));

// ==== dv/sleep_unit_partner.sv ====
// model of the functional units' request side (class 2 and class 3).
// assumes willing is set by the bench; units share the system clock.
`timescale 1ns/1ps

module sleep_unit_partner (
    input  logic       clock,         // system clock
    input  logic       srst,          // synchronous reset
    input  logic       sleepInitiate, // class 3 ask
    input  logic [8:0] willing,       // bit n: unit n may sleep now
    input  logic       slow,          // class 3 answers late
    output logic       grant,         // class 3 request
    output logic [6:0] requests       // class 2 units, bits 2..8
);
    logic [2:0] wait_r;
    always @(posedge clock) begin
        if (srst) begin
            grant <= 1'h0;
            wait_r <= 3'h0;
            requests <= 7'h0;
        end else begin
            requests <= willing[8:2];
            // unit withdraws, or gives up when the manager ends the ask
            if (!sleepInitiate || !willing[0]) begin
                grant <= 1'h0;
                wait_r <= 3'h0;
            end else if (wait_r == (slow ? 3'h4 : 3'h0)) begin
                grant <= 1'h1;
            end else begin
                wait_r <= wait_r + 3'h1;
            end
        end
    end
endmodule // sleep_unit_partner

// ==== dv/sleep_clock_gating_manager_test.sv ====
// self-checking bench for the sleep clock gating manager.
// assumes the four-phase register handshake and the unit partner model.
`timescale 1ns/1ps
`include "sleep_clock_gating_manager_regs.vh"

module sleep_clock_gating_manager_test;
    logic clock = 1'h0, srst = 1'h1, ctrlRead = 1'h0, ctrlWrite = 1'h0, slow = 1'h0;
    logic [9:0]  ctrlAddr = 10'h0;
    logic [31:0] ctrlWrData = 32'h0, q, one, c1;
    logic [8:0]  willing = 9'h0;
    wire  [31:0] ctrlRdData;
    wire  [6:0]  requests;
    wire ctrlAck, grant, twoWireBusUnitSleepInitiate, twoWireBusUnitSleep_n;
    wire processorCoreSleep_n, transferEngineSleep_n, bridgeSleep_n, decompressorSleep_n;
    wire externalBusUnitSleep_n, memoryControllerSleep_n, busArbiterSleep_n;
    wire generalPinUnitSleep_n, serialPortZeroSleep_n, serialPortOneSleep_n;
    wire interruptControllerSleep_n, coreTimerClockSleep_n;
    wire [31:0] asleep = {18'h0, ~{coreTimerClockSleep_n, interruptControllerSleep_n,
        serialPortOneSleep_n, serialPortZeroSleep_n, generalPinUnitSleep_n, busArbiterSleep_n,
        memoryControllerSleep_n, externalBusUnitSleep_n, decompressorSleep_n, bridgeSleep_n,
        transferEngineSleep_n, processorCoreSleep_n, 1'h1, twoWireBusUnitSleep_n}};
    wire [31:0] ask = {31'h0, twoWireBusUnitSleepInitiate};
    int errors = 0, comparisons = 0, i, b;

    always #2 clock = ~clock;

    sleep_clock_gating_manager DUT (.clock, .srst, .ctrlAddr, .ctrlRead, .ctrlWrite,
        .ctrlWrData, .ctrlRdData, .ctrlAck, .twoWireBusUnitSleepRequest(grant),
        .twoWireBusUnitSleepInitiate, .twoWireBusUnitSleep_n,
        .processorCoreSleepRequest(requests[0]), .transferEngineSleepRequest(requests[1]),
        .bridgeSleepRequest(requests[2]), .decompressorSleepRequest(requests[3]),
        .externalBusUnitSleepRequest(requests[4]), .memoryControllerSleepRequest(requests[5]),
        .busArbiterSleepRequest(requests[6]), .processorCoreSleep_n, .transferEngineSleep_n,
        .bridgeSleep_n, .decompressorSleep_n, .externalBusUnitSleep_n, .memoryControllerSleep_n,
        .busArbiterSleep_n, .generalPinUnitSleep_n, .serialPortZeroSleep_n,
        .serialPortOneSleep_n, .interruptControllerSleep_n, .coreTimerClockSleep_n);

    sleep_unit_partner units (.clock(clock), .srst(srst), .sleepInitiate(twoWireBusUnitSleepInitiate),
        .willing(willing), .slow(slow), .grant(grant), .requests(requests));

    // ==========
    // tasks
    task automatic give_verdict;
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // request held until the edge after ack is seen; a missing ack on a mapped address ends the run
    task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d,
                          input logic mapped, output logic [31:0] data);
        int n;
        logic seen;
        n = 0;
        seen = 1'h0;
        data = 32'h0;
        settle(1);
        ctrlAddr = a;
        ctrlWrData = d;
        ctrlWrite = wr;
        ctrlRead = !wr;
        while (!seen && n < 8) begin
            settle(1);
            seen = ctrlAck === 1'h1;
            data = ctrlRdData;
            n++;
        end
        if (seen) settle(1);
        ctrlRead = 1'h0;
        ctrlWrite = 1'h0;
        check("acknowledge", {31'h0, mapped}, {31'h0, seen});
        if (mapped && !seen) give_verdict;
        n = 0;
        while (ctrlAck !== 1'h0 && n < 8) begin
            settle(1);
            n++;
        end
        check("ack release", 32'h0, {31'h0, ctrlAck});
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] unused;
        access(1'h1, a, d, 1'h1, unused);
    endtask

    task automatic rd(input string what, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] got;
        access(1'h0, a, 32'h0, 1'h1, got);
        check(what, exp, got);
    endtask

    // ==========
    // sequence
    initial begin
        settle(20);
        srst = 1'h0;
        settle(2);
        check("sleep after reset", 32'h0, asleep);
        check("initiate after reset", 32'h0, ask);
        rd("status reset", `ADDR_SLEEP_STATUS, 32'hffff0000);
        rd("enable reset", `ADDR_SLEEP_ENABLE, 32'h0);
        rd("force reset", `ADDR_SLEEP_FORCE, 32'h0);
        wr(`ADDR_SLEEP_STATUS, 32'h0);
        rd("status read only", `ADDR_SLEEP_STATUS, 32'hffff0000);
        access(1'h0, 10'h0bb, 32'h0, 1'h0, q);
        wr(`ADDR_SLEEP_ENABLE, 32'hffffffff);
        rd("enable map", `ADDR_SLEEP_ENABLE, 32'h00003ffd);
        wr(`ADDR_SLEEP_ENABLE, 32'h0);
        wr(`ADDR_SLEEP_FORCE, 32'hffffffff);
        rd("force map", `ADDR_SLEEP_FORCE, 32'h00003ffd);
        settle(4);
        check("forced sleep", 32'h00003ffd, asleep);
        check("force initiate", 32'h0, ask);
        rd("forced status", `ADDR_SLEEP_STATUS, 32'hffff3ffd);
        wr(`ADDR_SLEEP_FORCE, 32'h0);
        settle(4);
        check("force released", 32'h0, asleep);
        // last pass repeats the class 3 unit with a slow grant
        for (i = 0; i < 15; i++) begin
            b = (i == 14) ? 0 : i;
            if (b == 1) continue;
            slow = i == 14;
            one = 32'h1 << b;
            c1 = (b >= `FIRST_CLASS1_BIT) ? one : 32'h0;
            willing = 9'h0;
            wr(`ADDR_SLEEP_ENABLE, one);
            settle(4);
            check("enable without request", c1, asleep);
            check("initiate raised", 32'(b == 0), ask);
            willing = 9'h1fd;
            settle(8);
            check("granted sleep", one, asleep);
            rd("status bit", `ADDR_SLEEP_STATUS, 32'hffff0000 | one);
            willing = 9'h0;
            settle(8);
            check("request withdrawn", c1, asleep);
            willing = 9'h1fd;
            settle(8);
            wr(`ADDR_SLEEP_ENABLE, 32'h0);
            check("enable cleared", 32'h0, asleep);
            check("initiate dropped", 32'h0, ask);
        end
        give_verdict;
    end
endmodule // sleep_clock_gating_manager_test
